// ===== hw/rst_pkg.sv
// Shared constants and types of the system reset controller
package rst_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses on the Wishbone bus)
    localparam logic [7:0] CAUSE_OFF = 8'h00;
    localparam logic [7:0] STATE_OFF = 8'h04;

    // Reset-cause register field positions
    localparam int POWER_UP_BIT = 0;
    localparam int PIN_BIT = 1;
    localparam int SAG_BIT = 2;
    localparam int DOG_BIT = 3;
    localparam int BUS_BIT = 5;

    // Value of the reset-cause register after a power-on reset
    localparam logic [7:0] CAUSE_RESET = 8'h01;
    // Bits that hold a flag; reserved positions read as zero
    localparam logic [7:0] CAUSE_MASK = 8'h2F;

    ////////////////////////////////////////////////////////////////////////////
    // Fuse coding
    localparam logic [2:0] SAG_OFF_CODE = 3'h7;
    // Clock-select bit that picks the slow-starting source class
    localparam int XTAL_SEL_BIT = 3;

    // Address where fetching starts after release
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_STRETCH = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic [2:0] sag_threshold_select;
        logic [1:0] startup_time_select;
        logic [3:0] clock_source_select;
    } fuse_t;

endpackage

// ===== hw/sync_hold.sv
// Asynchronous-assert, synchronous-release hold synchroniser
`timescale 1ns/100ps

module sync_hold #(
    parameter int WIDTH = 3
) (
    // Clock
    input wire logic clk_in,
    // Asynchronous source levels, active high
    input wire logic [WIDTH-1:0] src_in,
    // Held levels, released on the clock
    output logic [WIDTH-1:0] held_out
);

    wire [WIDTH-1:0] held_w;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            // Each bit owns its two stages so no flop has two writers
            logic meta_q;
            logic hold_q;

            // Source sets both stages at once, release walks two edges
            always_ff @(posedge clk_in or posedge src_in[i])
            begin
                if (src_in[i])
                begin
                    meta_q <= 1'b1;
                    hold_q <= 1'b1;
                end
                else
                begin
                    meta_q <= 1'b0;
                    hold_q <= meta_q;
                end
            end

            assign held_w[i] = hold_q;
        end
    endgenerate

    assign held_out = held_w;

endmodule

// ===== hw/system_reset_controller.sv
// System reset controller: source merge, reset stretch and reset-cause flags
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps

module system_reset_controller
    import rst_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int STRETCH_RC_CYC = 16,
    parameter int STRETCH_XTAL_CYC = 64
) (
    // Clock and bus reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Reset sources
    input wire logic por_low_in,
    input wire logic pin_reset_n_in,
    input wire logic sag_low_in,
    input wire logic dog_enable_in,
    input wire logic dog_expire_in,
    input wire logic usb_enable_in,
    input wire logic usb_reset_cpu_en_in,
    input wire logic usb_bus_reset_in,
    // Fuses
    input wire rst_pkg::fuse_t fuse_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Reset outputs
    output logic chip_reset_out,
    output logic port_init_out,
    output logic usb_ctrl_reset_out,
    output logic fetch_start_out,
    output logic [15:0] fetch_addr_out,
    // Sag comparator control
    output logic sag_enable_out,
    output logic [2:0] sag_level_out
);

    import rst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Stretch length from start-up and clock-select fuses
    function automatic logic [CNT_W-1:0] stretch_len(input fuse_t f);
        logic [CNT_W-1:0] base;
        base = f.clock_source_select[XTAL_SEL_BIT] ? CNT_W'(STRETCH_XTAL_CYC)
                                                   : CNT_W'(STRETCH_RC_CYC);
        return base << f.startup_time_select;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Source decoding
    wire sag_en = fuse_in.sag_threshold_select != SAG_OFF_CODE;
    wire sag_act = sag_en & sag_low_in;
    wire pin_low = ~pin_reset_n_in;
    wire usb_act = usb_enable_in & usb_reset_cpu_en_in & usb_bus_reset_in;
    // Clockless sources act on the reset flops directly
    wire async_set = rst_in | por_low_in | pin_low | sag_act;

    logic [2:0] held;
    logic dog_pulse_q;

    sync_hold #(
        .WIDTH(3)
    ) u_hold (
        .clk_in(clk_in),
        .src_in({sag_act, pin_low, por_low_in}),
        .held_out(held)
    );

    wire held_por = held[0];
    wire held_pin = held[1];
    wire held_sag = held[2];
    wire hold_other = (|held) | dog_pulse_q;
    wire hold_act = hold_other | usb_act;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog pulse, one clock long
    wire dog_pulse_d = dog_enable_in & dog_expire_in & ~dog_pulse_q;

    always_ff @(posedge clk_in or posedge async_set)
    begin
        if (async_set)
            dog_pulse_q <= 1'b0;
        else
            dog_pulse_q <= dog_pulse_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hold and stretch sequencer
    seq_state_t state_q;
    seq_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic chip_reset_q;
    logic port_init_q;
    logic usb_ctrl_reset_q;
    logic fetch_start_q;
    wire [CNT_W-1:0] len = stretch_len(fuse_in);

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            ST_RUN:
            begin
                if (hold_act)
                begin
                    state_d = ST_HOLD;
                    cnt_d = len;
                end
            end
            ST_HOLD:
            begin
                cnt_d = len;
                if (!hold_act)
                    state_d = ST_STRETCH;
            end
            ST_STRETCH:
            begin
                if (hold_act)
                begin
                    state_d = ST_HOLD;
                    cnt_d = len;
                end
                else if (cnt_q == '0)
                    state_d = ST_RUN;
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            default:
            begin
                state_d = ST_HOLD;
                cnt_d = len;
            end
        endcase
    end

    wire chip_reset_d = (state_d != ST_RUN);
    // USB controller is spared when only a bus reset is in play
    wire usb_ctrl_reset_d = hold_other | (usb_ctrl_reset_q & chip_reset_d);
    wire fetch_start_d = chip_reset_q & ~chip_reset_d;

    always_ff @(posedge clk_in or posedge async_set)
    begin
        if (async_set)
        begin
            state_q <= ST_HOLD;
            cnt_q <= '0;
            chip_reset_q <= 1'b1;
            port_init_q <= 1'b1;
            usb_ctrl_reset_q <= 1'b1;
            fetch_start_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            chip_reset_q <= chip_reset_d;
            port_init_q <= chip_reset_d;
            usb_ctrl_reset_q <= usb_ctrl_reset_d;
            fetch_start_q <= fetch_start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sag comparator control
    logic sag_enable_q;
    logic [2:0] sag_level_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sag_enable_q <= 1'b0;
            sag_level_q <= SAG_OFF_CODE;
        end
        else
        begin
            sag_enable_q <= sag_en;
            sag_level_q <= fuse_in.sag_threshold_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave decode
    logic ack_q;
    logic [31:0] rd_q;
    logic [7:0] cause_q;

    wire bus_req = wb_cyc_in & wb_stb_in & ~ack_q;
    wire hit_cause = wb_adr_in == CAUSE_OFF;
    wire hit_state = wb_adr_in == STATE_OFF;
    // Write lands at the edge where the master sees ack high
    wire cause_wr = wb_cyc_in & wb_stb_in & ack_q & wb_we_in & hit_cause & wb_sel_in[0];
    wire [31:0] rd_sel = hit_cause ? {24'h0, cause_q & CAUSE_MASK}
                       : hit_state ? {28'h0, usb_ctrl_reset_q, state_q}
                       : 32'h0;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_q <= 1'b0;
            rd_q <= 32'h0;
        end
        else
        begin
            ack_q <= bus_req;
            rd_q <= (bus_req & ~wb_we_in) ? rd_sel : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset-cause flags, reset only by power-on, cleared by writing zero over the bus; set wins over clear
    wire [7:0] flag_set = {2'b00, usb_act, 1'b0, dog_pulse_q, held_sag,
                           held_pin, 1'b0};
    wire [7:0] flag_clr = cause_wr ? ~wb_dat_in[7:0] : 8'h00;
    wire [7:0] cause_d = ((cause_q & ~flag_clr) | flag_set) & CAUSE_MASK;

    always_ff @(posedge clk_in or posedge por_low_in)
    begin
        if (por_low_in)
            cause_q <= CAUSE_RESET;
        else
            cause_q <= cause_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_dat_out = rd_q;
    assign wb_ack_out = ack_q;
    assign chip_reset_out = chip_reset_q;
    assign port_init_out = port_init_q;
    assign usb_ctrl_reset_out = usb_ctrl_reset_q;
    assign fetch_start_out = fetch_start_q;
    assign fetch_addr_out = RESET_VECTOR;
    assign sag_enable_out = sag_enable_q;
    assign sag_level_out = sag_level_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [CNT_W:0] quiet_q;

    // Counts cycles of reset with no source held
    always_ff @(posedge clk_in or posedge async_set)
    begin
        if (async_set)
            quiet_q <= '0;
        else if (hold_act)
            quiet_q <= '0;
        else if (chip_reset_q)
            quiet_q <= quiet_q + (CNT_W + 1)'(1);
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in || por_low_in);

    dog_one_cycle_a: assert property (
        dog_pulse_q |=> !dog_pulse_q)
        else $error("watchdog reset pulse longer than one cycle");

    dog_gated_a: assert property (
        $rose(dog_pulse_q) |-> $past(dog_enable_in) && $past(dog_expire_in))
        else $error("watchdog reset without enabled expiry");

    hold_keeps_a: assert property (
        hold_act |=> chip_reset_q && port_init_q)
        else $error("reset released while a source is held");

    stretch_len_a: assert property (
        $fell(chip_reset_q) && $past(state_q) == ST_STRETCH
        |-> quiet_q == {1'b0, len} + (CNT_W + 1)'(2))
        else $error("stretch length differs from fuse selection");

    fetch_on_release_a: assert property (
        $fell(chip_reset_q) |-> fetch_start_q ##1 !fetch_start_q)
        else $error("fetch start missing at release");

    usb_spared_a: assert property (
        usb_act && !hold_other && !usb_ctrl_reset_q |=> chip_reset_q && !usb_ctrl_reset_q)
        else $error("usb bus reset touched the usb controller");

    usb_flag_a: assert property (
        usb_act |=> cause_q[BUS_BIT])
        else $error("usb cause flag not set");

    dog_flag_a: assert property (
        dog_pulse_q |=> cause_q[DOG_BIT] && chip_reset_q)
        else $error("watchdog cause flag not set");

    sag_flag_a: assert property (
        held_sag |=> cause_q[SAG_BIT])
        else $error("sag cause flag not set");

    pin_flag_a: assert property (
        held_pin |=> cause_q[PIN_BIT])
        else $error("pin cause flag not set");

    reserved_zero_a: assert property (
        wb_ack_out |-> wb_dat_out[7:6] == 2'b00 && cause_q[4] == 1'b0)
        else $error("reserved cause bits not zero");

    flag_sticky_a: assert property (
        cause_q[POWER_UP_BIT] && !(cause_wr && !wb_dat_in[POWER_UP_BIT])
        |=> cause_q[POWER_UP_BIT])
        else $error("power-up flag lost without software clear");

    ack_single_a: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");

    dog_release_c: cover property (
        dog_pulse_q ##1 (chip_reset_q && !hold_act) [*3] ##[1:600] $fell(chip_reset_q));

    usb_reset_c: cover property (
        usb_act && !usb_ctrl_reset_q ##[1:600] fetch_start_q);

    flag_clear_c: cover property (
        cause_q[DOG_BIT] ##1 cause_wr ##1 !cause_q[DOG_BIT]);

    sag_pin_c: cover property (
        held_pin ##[1:50] held_sag);

endmodule

// ===== tb/src_model.sv
// Behavioural model of the reset sources around the controller
`timescale 1ns/100ps

module src_model (
    // Clock and requests from the bench
    input wire logic clk_in,
    input wire logic [6:0] req_in,
    // Source levels towards the controller
    output logic por_low_out,
    output logic pin_reset_n_out,
    output logic sag_low_out,
    output logic dog_enable_out,
    output logic dog_expire_out,
    output logic usb_enable_out,
    output logic usb_reset_cpu_en_out,
    output logic usb_bus_reset_out
);
    logic fire_q;

    ////////////////////////////////////////////////////////////////////////////
    // Levels follow the requests; the pin is active low
    assign por_low_out = req_in[0];
    assign pin_reset_n_out = ~req_in[1];
    assign sag_low_out = req_in[2];
    assign dog_enable_out = req_in[3];
    // Expiry is a single-cycle pulse on a rising fire request
    always_ff @(posedge clk_in) fire_q <= req_in[4];
    assign dog_expire_out = req_in[4] & ~fire_q;
    // Request 6 gives a bus reset with the processor option off
    assign usb_enable_out = req_in[5] | req_in[6];
    assign usb_reset_cpu_en_out = req_in[5];
    assign usb_bus_reset_out = req_in[5] | req_in[6];
endmodule

// ===== tb/system_reset_controller_tb.sv
// Self-checking bench for the system reset controller
`timescale 1ns/100ps

module system_reset_controller_tb;
    import rst_pkg::*;
    localparam int RC = 16;
    localparam int XT = 64;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] req = 7'h01;
    fuse_t fuse = '{3'h6, 2'h0, 4'h0};
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wd = 32'h0, wb_rd;
    logic wb_ack, chip_rst, port_init, usb_rst_o, fetch_start, sag_en;
    logic [15:0] fetch_addr;
    logic [2:0] sag_lvl;
    logic por_l, pin_n, sag_l, dog_en, dog_exp, usb_en, usb_opt, usb_br;
    logic [31:0] seed = 32'h0000E1F3;
    logic [7:0] cause_m;
    int srcs[4] = '{1, 2, 4, 5};
    int bad_count = 0;
    int n_tests = 0;

    always #4 clk_in = ~clk_in;

    src_model src (.clk_in(clk_in), .req_in(req), .por_low_out(por_l),
        .pin_reset_n_out(pin_n), .sag_low_out(sag_l), .dog_enable_out(dog_en),
        .dog_expire_out(dog_exp), .usb_enable_out(usb_en), .usb_reset_cpu_en_out(usb_opt),
        .usb_bus_reset_out(usb_br));

    system_reset_controller #(.CNT_W(16), .STRETCH_RC_CYC(RC), .STRETCH_XTAL_CYC(XT)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .por_low_in(por_l), .pin_reset_n_in(pin_n),
        .sag_low_in(sag_l), .dog_enable_in(dog_en), .dog_expire_in(dog_exp),
        .usb_enable_in(usb_en), .usb_reset_cpu_en_in(usb_opt), .usb_bus_reset_in(usb_br),
        .fuse_in(fuse), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wd), .wb_dat_out(wb_rd),
        .wb_ack_out(wb_ack), .chip_reset_out(chip_rst), .port_init_out(port_init),
        .usb_ctrl_reset_out(usb_rst_o), .fetch_start_out(fetch_start),
        .fetch_addr_out(fetch_addr), .sag_enable_out(sag_en), .sag_level_out(sag_lvl));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        bad_count++;
        $display("BAD %s expected answer seen timeout", what);
        give_verdict();
    endtask

    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wd <= wd;
        wb_sel <= 4'hF;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50)
            hang("wb_ack");
        rd = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_io(1'b0, adr, 32'h0, rd);
        chk("read", exp, rd);
    endtask

    task automatic wait_rel(output int n);
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (chip_rst !== 1'b0 && n < 2000);
        if (n >= 2000)
            hang("release");
        chk("fetch_start", 1, fetch_start);
        chk("fetch_addr", RESET_VECTOR, fetch_addr);
    endtask

    task automatic no_rst(input logic [6:0] r);
        req <= r;
        repeat (4) @(posedge clk_in);
        chk("no_reset", 0, chip_rst);
        req <= 7'h00;
        @(posedge clk_in);
    endtask

    // One source: assert, hold, release, then check stretch and flag
    task automatic run_src(input int s);
        int n;
        int len;
        logic [31:0] r;
        logic [31:0] rd;
        r = rnd();
        fuse <= '{{1'b0, r[1:0]}, r[5:4], {r[8], 3'h0}};
        @(posedge clk_in);
        len = (r[8] ? XT : RC) << r[5:4];
        req <= (s == 4) ? 7'h18 : 7'(1 << s);
        repeat ((s == 4) ? 3 : 4) @(posedge clk_in);
        chk("chip_reset", 1, chip_rst);
        chk("port_init", 1, port_init);
        chk("usb_ctrl_reset", (s == 5) ? 0 : 1, usb_rst_o);
        req <= 7'h00;
        wait_rel(n);
        chk("stretch_len", 1, n >= len && n <= len + 6);
        cause_m = cause_m | 8'(1 << ((s == 4) ? DOG_BIT : s));
        rchk(CAUSE_OFF, cause_m);
        r = rnd();
        wb_io(1'b1, CAUSE_OFF, r, rd);
        cause_m = cause_m & r[7:0];
        rchk(CAUSE_OFF, cause_m);
        $display("done source %0d", s);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int n;
        logic [31:0] rd;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        req <= 7'h00;
        wait_rel(n);
        rchk(CAUSE_OFF, CAUSE_RESET);
        rchk(STATE_OFF, 32'h1);
        rchk(8'h10, 32'h0);
        wb_io(1'b1, CAUSE_OFF, 32'h0, rd);
        cause_m = 8'h00;
        rchk(CAUSE_OFF, 32'h0);
        $display("done power up");
        foreach (srcs[i])
            run_src(srcs[i]);
        no_rst(7'h10);
        no_rst(7'h40);
        fuse.sag_threshold_select <= SAG_OFF_CODE;
        repeat (2) @(posedge clk_in);
        no_rst(7'h04);
        rchk(CAUSE_OFF, cause_m);
        for (int c = 0; c < 8; c++)
        begin
            fuse.sag_threshold_select <= 3'(c);
            repeat (2) @(posedge clk_in);
            chk("sag_enable", c != 7, sag_en);
            chk("sag_level", c, sag_lvl);
        end
        $display("done no-reset cases");
        req <= 7'h02;
        repeat (4) @(posedge clk_in);
        req <= 7'h00;
        wait_rel(n);
        cause_m = cause_m | 8'h02;
        rchk(CAUSE_OFF, cause_m);
        req <= 7'h01;
        repeat (4) @(posedge clk_in);
        chk("por_reset", 1, chip_rst);
        req <= 7'h00;
        wait_rel(n);
        rchk(CAUSE_OFF, CAUSE_RESET);
        wb_io(1'b1, CAUSE_OFF, 32'hFF, rd);
        rchk(CAUSE_OFF, CAUSE_RESET);
        $display("done power-on clear");
        give_verdict();
    end
endmodule
